// [include/sasp_defines.svh]
`ifndef SASP_DEFINES_SVH
`define SASP_DEFINES_SVH

// Register byte offsets
`define SASP_OFF_CTRL 8'h00
`define SASP_OFF_MODE 8'h04
`define SASP_OFF_PSCL 8'h08
`define SASP_OFF_FCTL 8'h0c
`define SASP_OFF_FIFO 8'h10

// Reset values of the writable fields
`define SASP_RST_CTRL 6'h00
`define SASP_RST_MODE 9'h000
`define SASP_RST_PSCL 10'h000
`define SASP_RST_FCTL 4'h0

// Read-only bit positions in the control word
`define SASP_CTRL_IDX_BIT 8
`define SASP_CTRL_TXRDY_BIT 7
`define SASP_CTRL_RXRDY_BIT 6

// Buffer geometry
`define SASP_FIFO_DEPTH 6'd32
`define SASP_PTR_W 5
`define SASP_WORD_W 16

// AXI responses
`define SASP_RESP_OKAY 2'b00
`define SASP_RESP_SLVERR 2'b10

`endif

// [include/sasp_pkg.sv]
package sasp_pkg;

    typedef enum logic [1:0] {
        SASP_DIR_NONE = 2'b00,
        SASP_DIR_RX = 2'b01,
        SASP_DIR_TX = 2'b10,
        SASP_DIR_TXRX = 2'b11
    } sasp_dir_t;

    typedef enum logic [1:0] {
        SASP_BCK_16FS = 2'b00,
        SASP_BCK_32FS = 2'b01,
        SASP_BCK_48FS = 2'b10,
        SASP_BCK_NA = 2'b11
    } sasp_bck_t;

    typedef struct packed {
        logic tx_dma_en;
        logic rx_dma_en;
        logic tx_idle;
        logic rx_idle;
        logic pscl_en;
        logic if_en;
    } sasp_ctrl_t;

    typedef struct packed {
        logic slave;
        sasp_dir_t dir;
        logic left_high;
        logic msb_just;
        logic width16;
        logic mclk384;
        sasp_bck_t bck;
    } sasp_mode_t;

    typedef struct packed {
        logic [4:0] div_a;
        logic [4:0] div_b;
    } sasp_pscl_t;

    typedef struct packed {
        logic tx_dma;
        logic rx_dma;
        logic tx_en;
        logic rx_en;
    } sasp_fctl_t;

endpackage

// [src/sasp_top.sv]
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "sasp_defines.svh"


module sasp_fifo (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic flush,
    input wire logic push,
    input wire logic [15:0] din,
    input wire logic pop,
    // Status
    output logic [15:0] dout,
    output logic [5:0] count
);
    logic [15:0] mem_ff [0:31];
    logic [4:0] wr_ff;
    logic [4:0] rd_ff;
    logic [5:0] cnt_ff;
    logic do_push;
    logic do_pop;

    assign do_push = push && (cnt_ff != `SASP_FIFO_DEPTH);
    assign do_pop = pop && (cnt_ff != 6'h00);
    assign dout = mem_ff[rd_ff];
    assign count = cnt_ff;

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_ff[wr_ff] <= din;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ff <= 5'h00;
            rd_ff <= 5'h00;
            cnt_ff <= 6'h00;
        end else if (flush) begin
            wr_ff <= 5'h00;
            rd_ff <= 5'h00;
            cnt_ff <= 6'h00;
        end else begin
            if (do_push) begin
                wr_ff <= wr_ff + 5'h01;
            end
            if (do_pop) begin
                rd_ff <= rd_ff + 5'h01;
            end
            cnt_ff <= cnt_ff + {5'h00, do_push} - {5'h00, do_pop};
        end
    end
endmodule // sasp_fifo

module sasp_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Audio link
    input wire logic serial_bit_clock_i,
    output logic serial_bit_clock_o,
    output logic serial_bit_clock_oe,
    input wire logic channel_select_i,
    output logic channel_select_o,
    output logic channel_select_oe,
    input wire logic audio_serial_in,
    output logic audio_serial_out,
    output logic codec_master_clock,
    // DMA requests
    output logic tx_dma_req,
    output logic rx_dma_req
);
    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Half bit-clock period in master-clock ticks
    function automatic logic [4:0] half_ticks(input logic m384, input sasp_pkg::sasp_bck_t b);
        logic [4:0] r;
        r = 5'd4;
        case (b)
            sasp_pkg::SASP_BCK_16FS: r = m384 ? 5'd12 : 5'd8;
            sasp_pkg::SASP_BCK_32FS: r = m384 ? 5'd6 : 5'd4;
            default: r = m384 ? 5'd4 : 5'd3;
        endcase
        return r;
    endfunction

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    sasp_pkg::sasp_ctrl_t ctrl_ff;
    sasp_pkg::sasp_mode_t mode_ff;
    sasp_pkg::sasp_pscl_t pscl_ff;
    sasp_pkg::sasp_fctl_t fctl_ff;
    logic aw_ok_ff, w_ok_ff, bvalid_ff, rvalid_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic do_wr, do_rd;
    logic [31:0] rd_word;
    logic rd_hit;
    logic [15:0] tx_dout, rx_dout, rx_din;
    logic [5:0] tx_cnt, rx_cnt;
    logic tx_push, tx_pop, rx_push, rx_pop;
    logic tx_flag, rx_flag;
    logic lr_ff;

    assign tx_flag = (tx_cnt != 6'h00);
    assign rx_flag = (rx_cnt != `SASP_FIFO_DEPTH);

    assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
    assign s_axi_wready = !w_ok_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign do_wr = aw_ok_ff && w_ok_ff && !bvalid_ff;
    assign do_rd = s_axi_arvalid && !rvalid_ff;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `SASP_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_ok_ff <= 1'b0;
                w_ok_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                if (awaddr_ff == `SASP_OFF_CTRL || awaddr_ff == `SASP_OFF_MODE ||
                    awaddr_ff == `SASP_OFF_PSCL || awaddr_ff == `SASP_OFF_FCTL ||
                    awaddr_ff == `SASP_OFF_FIFO) begin
                    bresp_ff <= `SASP_RESP_OKAY;
                end else begin
                    bresp_ff <= `SASP_RESP_SLVERR;
                end
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff <= `SASP_RST_CTRL;
            mode_ff <= `SASP_RST_MODE;
            pscl_ff <= `SASP_RST_PSCL;
            fctl_ff <= `SASP_RST_FCTL;
        end else if (do_wr) begin
            if (awaddr_ff == `SASP_OFF_CTRL) begin
                ctrl_ff <= 6'(merge_strb({26'h0, ctrl_ff}, wdata_ff, wstrb_ff));
            end else if (awaddr_ff == `SASP_OFF_MODE) begin
                mode_ff <= 9'(merge_strb({23'h0, mode_ff}, wdata_ff, wstrb_ff));
            end else if (awaddr_ff == `SASP_OFF_PSCL) begin
                pscl_ff <= 10'(merge_strb({22'h0, pscl_ff}, wdata_ff, wstrb_ff));
            end else if (awaddr_ff == `SASP_OFF_FCTL) begin
                fctl_ff <= 4'(merge_strb({16'h0, fctl_ff, 12'h000}, wdata_ff, wstrb_ff) >> 12);
            end
        end
    end

    // Halfword access to the buffer window, one entry per access
    assign tx_push = do_wr && (awaddr_ff == `SASP_OFF_FIFO) && (wstrb_ff[1:0] != 2'b00);
    assign rx_pop = do_rd && (s_axi_araddr == `SASP_OFF_FIFO);

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        if (s_axi_araddr == `SASP_OFF_CTRL) begin
            rd_word = {23'h0, lr_ff ^ mode_ff.left_high, tx_flag, rx_flag, ctrl_ff};
        end else if (s_axi_araddr == `SASP_OFF_MODE) begin
            rd_word = {23'h0, mode_ff};
        end else if (s_axi_araddr == `SASP_OFF_PSCL) begin
            rd_word = {22'h0, pscl_ff};
        end else if (s_axi_araddr == `SASP_OFF_FCTL) begin
            rd_word = {16'h0, fctl_ff, tx_cnt, rx_cnt};
        end else if (s_axi_araddr == `SASP_OFF_FIFO) begin
            rd_word = {16'h0, (rx_cnt != 6'h00) ? rx_dout : 16'h0000};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `SASP_RESP_OKAY;
        end else if (do_rd) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= rd_hit ? `SASP_RESP_OKAY : `SASP_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign tx_dma_req = fctl_ff.tx_dma && ctrl_ff.tx_dma_en && tx_flag;
    assign rx_dma_req = fctl_ff.rx_dma && ctrl_ff.rx_dma_en && rx_flag && (rx_cnt != 6'h00);

    // --------------------------------------------------------------
    // Buffers
    // --------------------------------------------------------------
    sasp_fifo u_out_buf (
        .clk(sys_clk), .resetn(resetn), .flush(!fctl_ff.tx_en), .push(tx_push),
        .din(wdata_ff[15:0]), .pop(tx_pop), .dout(tx_dout), .count(tx_cnt)
    );
    sasp_fifo u_in_buf (
        .clk(sys_clk), .resetn(resetn), .flush(!fctl_ff.rx_en), .push(rx_push),
        .din(rx_din), .pop(rx_pop), .dout(rx_dout), .count(rx_cnt)
    );

    // --------------------------------------------------------------
    // Dual prescaler
    // --------------------------------------------------------------
    logic [4:0] pa_ff, pb_ff;
    logic mclk_en_ff, cdclk_ff, run;

    assign run = ctrl_ff.if_en && ctrl_ff.pscl_en;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pa_ff <= 5'h00;
            pb_ff <= 5'h00;
            mclk_en_ff <= 1'b0;
            cdclk_ff <= 1'b0;
        end else if (!run) begin
            pa_ff <= 5'h00;
            pb_ff <= 5'h00;
            mclk_en_ff <= 1'b0;
            cdclk_ff <= 1'b0;
        end else begin
            pa_ff <= (pa_ff >= pscl_ff.div_a) ? 5'h00 : pa_ff + 5'h01;
            mclk_en_ff <= (pa_ff >= pscl_ff.div_a);
            pb_ff <= (pb_ff >= pscl_ff.div_b) ? 5'h00 : pb_ff + 5'h01;
            cdclk_ff <= (pb_ff <= (pscl_ff.div_b >> 1));
        end
    end
    assign codec_master_clock = cdclk_ff;

    // --------------------------------------------------------------
    // Bit clock and channel generator
    // --------------------------------------------------------------
    logic [4:0] half_ff;
    logic [4:0] slot_ff;
    logic sclk_ff, grise_ff, gfall_ff, gen_run;
    logic [4:0] slot_bits;

    assign slot_bits = (mode_ff.bck == sasp_pkg::SASP_BCK_16FS) ? 5'd8 :
                       (mode_ff.bck == sasp_pkg::SASP_BCK_32FS) ? 5'd16 : 5'd24;
    assign gen_run = run && !mode_ff.slave && !(ctrl_ff.tx_idle && ctrl_ff.rx_idle);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            half_ff <= 5'h00;
            slot_ff <= 5'h00;
            sclk_ff <= 1'b0;
            grise_ff <= 1'b0;
            gfall_ff <= 1'b0;
        end else begin
            grise_ff <= 1'b0;
            gfall_ff <= 1'b0;
            if (gen_run && mclk_en_ff) begin
                if (half_ff >= half_ticks(mode_ff.mclk384, mode_ff.bck) - 5'd1) begin
                    half_ff <= 5'h00;
                    sclk_ff <= !sclk_ff;
                    grise_ff <= !sclk_ff;
                    gfall_ff <= sclk_ff;
                    if (sclk_ff) begin
                        slot_ff <= (slot_ff >= slot_bits - 5'd1) ? 5'h00 : slot_ff + 5'h01;
                    end
                end else begin
                    half_ff <= half_ff + 5'h01;
                end
            end
        end
    end

    // --------------------------------------------------------------
    // Slave pin synchronisers and channel select
    // --------------------------------------------------------------
    logic [2:0] sck_s_ff;
    logic [1:0] cs_s_ff, sd_s_ff;
    logic rise_ev, fall_ev, lr_now;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sck_s_ff <= 3'h0;
            cs_s_ff <= 2'h0;
            sd_s_ff <= 2'h0;
        end else begin
            sck_s_ff <= {sck_s_ff[1:0], serial_bit_clock_i};
            cs_s_ff <= {cs_s_ff[0], channel_select_i};
            sd_s_ff <= {sd_s_ff[0], audio_serial_in};
        end
    end

    assign rise_ev = mode_ff.slave ? (sck_s_ff[1] && !sck_s_ff[2]) : grise_ff;
    assign fall_ev = mode_ff.slave ? (!sck_s_ff[1] && sck_s_ff[2]) : gfall_ff;
    assign lr_now = mode_ff.slave ? cs_s_ff[1] : lr_ff;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lr_ff <= 1'b1;
        end else if (mode_ff.slave) begin
            if (ctrl_ff.if_en && rise_ev) begin
                lr_ff <= cs_s_ff[1];
            end
        end else if (gen_run && mclk_en_ff && sclk_ff &&
                     half_ff >= half_ticks(mode_ff.mclk384, mode_ff.bck) - 5'd1 &&
                     slot_ff >= slot_bits - 5'd1) begin
            lr_ff <= !lr_ff;
        end
    end

    assign serial_bit_clock_o = sclk_ff;
    assign serial_bit_clock_oe = ctrl_ff.if_en && !mode_ff.slave;
    assign channel_select_o = lr_ff;
    assign channel_select_oe = ctrl_ff.if_en && !mode_ff.slave;

    // --------------------------------------------------------------
    // Transmit shifter
    // --------------------------------------------------------------
    logic tx_act, rx_act, tx_lr_ff, tx_wait_ff, sdo_ff;
    logic [15:0] tx_sh_ff, tx_word;

    assign tx_act = ctrl_ff.if_en && !ctrl_ff.tx_idle && fctl_ff.tx_en &&
                    (mode_ff.dir == sasp_pkg::SASP_DIR_TX || mode_ff.dir == sasp_pkg::SASP_DIR_TXRX);
    assign rx_act = ctrl_ff.if_en && !ctrl_ff.rx_idle && fctl_ff.rx_en &&
                    (mode_ff.dir == sasp_pkg::SASP_DIR_RX || mode_ff.dir == sasp_pkg::SASP_DIR_TXRX);
    assign tx_pop = tx_act && fall_ev && (lr_ff != tx_lr_ff);
    // Narrow samples ride in the low byte and go out MSB-aligned
    assign tx_word = !tx_flag ? 16'h0000 : mode_ff.width16 ? tx_dout : {tx_dout[7:0], 8'h00};

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tx_lr_ff <= 1'b1;
            tx_wait_ff <= 1'b0;
            tx_sh_ff <= 16'h0000;
            sdo_ff <= 1'b0;
        end else if (!tx_act) begin
            tx_lr_ff <= lr_ff;
            tx_wait_ff <= 1'b0;
            tx_sh_ff <= 16'h0000;
            sdo_ff <= 1'b0;
        end else if (fall_ev) begin
            tx_lr_ff <= lr_ff;
            if (lr_ff != tx_lr_ff) begin
                if (mode_ff.msb_just) begin
                    sdo_ff <= tx_word[15];
                    tx_sh_ff <= {tx_word[14:0], 1'b0};
                end else begin
                    // Last bit of the previous word spills into the new slot
                    sdo_ff <= tx_sh_ff[15];
                    tx_sh_ff <= tx_word;
                    tx_wait_ff <= 1'b1;
                end
            end else begin
                sdo_ff <= tx_sh_ff[15];
                tx_sh_ff <= {tx_sh_ff[14:0], 1'b0};
                tx_wait_ff <= 1'b0;
            end
        end
    end
    assign audio_serial_out = sdo_ff;

    // --------------------------------------------------------------
    // Receive shifter
    // --------------------------------------------------------------
    logic rx_lr_ff;
    logic [4:0] rx_n_ff;
    logic [15:0] rx_sh_ff, rx_fill;
    logic rx_chg;
    logic [4:0] wlen;

    assign wlen = mode_ff.width16 ? 5'd16 : 5'd8;
    assign rx_chg = rise_ev && (lr_now != rx_lr_ff);
    // Place the bit at the current position only while inside the word
    assign rx_fill = (rx_n_ff < wlen) ? (rx_sh_ff | (16'(sd_s_ff[1]) << (5'd15 - rx_n_ff))) : rx_sh_ff;
    assign rx_din = mode_ff.width16 ? (mode_ff.msb_just ? rx_sh_ff : rx_fill) :
                    {8'h00, mode_ff.msb_just ? rx_sh_ff[15:8] : rx_fill[15:8]};
    assign rx_push = rx_act && rx_chg;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rx_lr_ff <= 1'b1;
            rx_n_ff <= 5'h00;
            rx_sh_ff <= 16'h0000;
        end else if (!rx_act) begin
            rx_lr_ff <= lr_now;
            rx_n_ff <= 5'h00;
            rx_sh_ff <= 16'h0000;
        end else if (rise_ev) begin
            rx_lr_ff <= lr_now;
            if (rx_chg && mode_ff.msb_just) begin
                rx_sh_ff <= {sd_s_ff[1], 15'h0000};
                rx_n_ff <= 5'd1;
            end else if (rx_chg) begin
                rx_sh_ff <= 16'h0000;
                rx_n_ff <= 5'h00;
            end else begin
                rx_sh_ff <= rx_fill;
                rx_n_ff <= (rx_n_ff < wlen) ? rx_n_ff + 5'h01 : rx_n_ff;
            end
        end
    end
endmodule // sasp_top

// [verif/sasp_chk.sv]
`timescale 1ns/1ps
module sasp_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Register bus
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Audio link
    input wire logic serial_bit_clock_o,
    input wire logic serial_bit_clock_oe,
    input wire logic channel_select_o,
    input wire logic channel_select_oe,
    input wire logic audio_serial_out
);
    // --------
    // Properties
    // --------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence rd_waiting;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    rd_answer_a: assert property (rd_taken |=> s_axi_rvalid) else $error("read answer late");
    rd_hold_a: assert property (rd_waiting |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
    oe_pair_a: assert property (serial_bit_clock_oe == channel_select_oe) else $error("link enables differ");
    half_min_a: assert property (serial_bit_clock_oe && $changed(serial_bit_clock_o) |=>
        ($stable(serial_bit_clock_o) || !serial_bit_clock_oe)[*2]) else $error("bit clock half too short");
    sel_fall_a: assert property (channel_select_oe && $past(channel_select_oe) && $changed(channel_select_o)
        |-> !serial_bit_clock_o) else $error("select moved on high clock");
    data_fall_a: assert property (serial_bit_clock_oe && $past(serial_bit_clock_oe) && $changed(audio_serial_out)
        |-> !serial_bit_clock_o) else $error("data moved on high clock");
    rst_idle_a: assert property ($rose(resetn) |-> !audio_serial_out && !serial_bit_clock_oe && channel_select_o)
        else $error("link not idle after reset");
endmodule // sasp_chk

bind sasp_top sasp_chk chk_u (.*);

// [verif/sasp_codec_model.sv]
`timescale 1ns/1ps
module sasp_codec_model #(
    parameter logic [15:0] PAT = 16'h0000
) (
    // Link from the port
    input wire logic bck,
    input wire logic lr,
    input wire logic din,
    // Codec answer
    output logic dout,
    output logic [15:0] got
);
    logic [15:0] rx_sh = 16'h0000;
    logic [15:0] tx_sh = 16'h0000;
    logic lr_r = 1'h1;
    logic lr_f = 1'h1;
    initial dout = 1'h0;
    // Capture on the rising edge, word closes when select moves
    always @(posedge bck) begin
        rx_sh <= {rx_sh[14:0], din};
        if (lr != lr_r) begin
            got <= {rx_sh[14:0], din};
        end
        lr_r <= lr;
    end
    // Launch on the falling edge, MSB one bit after the select change
    always @(negedge bck) begin
        dout <= (lr_r != lr_f) ? PAT[15] : tx_sh[15];
        tx_sh <= (lr_r != lr_f) ? {PAT[14:0], 1'h0} : {tx_sh[14:0], 1'h0};
        lr_f <= lr_r;
    end
endmodule // sasp_codec_model

// [verif/stereo_audio_serial_port_bench.sv]
`timescale 1ns/1ps
module stereo_audio_serial_port_bench;
    localparam logic [15:0] PAT = 16'hb4c3;
    logic sys_clk = 1'h0, resetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, m, x = 32'h0000c70d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, po, pc;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic serial_bit_clock_i, serial_bit_clock_o, serial_bit_clock_oe, channel_select_i, channel_select_o;
    logic channel_select_oe, audio_serial_in, audio_serial_out, codec_master_clock, tx_dma_req, rx_dma_req;
    logic [15:0] got, q [32];
    int errors = 0, compares = 0, cyc = 0, pb, pm, cb, cm;

    always #50 sys_clk = ~sys_clk;
    assign serial_bit_clock_i = serial_bit_clock_oe ? serial_bit_clock_o : 1'h0;
    assign channel_select_i = channel_select_oe ? channel_select_o : 1'h1;
    sasp_top dut_u (.*);
    sasp_codec_model #(.PAT(PAT)) codec_u (.bck(serial_bit_clock_i), .lr(channel_select_i),
        .din(audio_serial_out), .dout(audio_serial_in), .got(got));

    // Rise-to-rise periods of both generated clocks
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        cb <= (serial_bit_clock_o && !po) ? 1 : cb + 1;
        cm <= (codec_master_clock && !pc) ? 1 : cm + 1;
        if (serial_bit_clock_o && !po) pb <= cb;
        if (codec_master_clock && !pc) pm <= cm;
        po <= serial_bit_clock_o;
        pc <= codec_master_clock;
        if (cyc == 20000) begin
            errors++;
            end_sim();
        end
    end

    function automatic logic [31:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    function automatic logic inq(logic [15:0] w);
        foreach (q[i]) if (q[i] === w) return 1'h1;
        return 1'h0;
    endfunction
    // Bit clock period at 16-bit, 32fs, 256fs
    function automatic logic [31:0] bper(int a);
        return 32'(8 * (a + 1));
    endfunction

    task automatic chk(logic [31:0] g, logic [31:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] v);
        logic ta, tw, b;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        b = 1'h0;
        while (!b) begin
            @(negedge sys_clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge sys_clk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(logic [7:0] a);
        logic ta, b;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        b = 1'h0;
        while (!b) begin
            @(negedge sys_clk);
            ta = s_axi_arvalid && s_axi_arready;
            b = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge sys_clk);
            if (ta) s_axi_arvalid <= 1'h0;
        end
        s_axi_rready <= 1'h0;
    endtask
    task automatic rc(logic [7:0] a, logic [31:0] e);
        rd(a);
        chk(d, e);
        chk(32'(r), 32'h0);
    endtask
    task automatic end_sim();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        resetn <= 1'h1;
        rc(8'h00, 32'h140);
        rc(8'h04, 32'h0);
        rc(8'h08, 32'h0);
        rc(8'h0c, 32'h0);
        rd(8'h14);
        chk(32'(r), 32'h2);
        wr(8'h14, 32'h1);
        chk(32'(r), 32'h2);
        for (int i = 0; i < 4; i++) begin
            m = (32'(i) << 6) | (rnd() & 32'h11f);
            wr(8'h04, m);
            rc(8'h04, m);
        end
        $display("test regs done");
        wr(8'h0c, 32'h3000);
        for (int i = 0; i < 33; i++) begin
            m = rnd() & 32'hffff;
            if (i < 32) q[i] = m[15:0];
            wr(8'h10, m);
        end
        rc(8'h0c, 32'h3000 | (32'h20 << 6));
        rc(8'h00, 32'h1c0);
        wr(8'h0c, 32'hf000);
        wr(8'h00, 32'h30);
        @(negedge sys_clk);
        chk(32'({tx_dma_req, rx_dma_req}), 32'h2);
        $display("test fill done");
        m = 32'h1 + rnd() % 32'hf;
        wr(8'h08, 32'h20 | m);
        wr(8'h04, 32'hc9);
        wr(8'h00, 32'h33);
        repeat (3000) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(32'(pb), bper(1));
        chk(32'(pm), m + 32'h1);
        chk(32'(inq(got)), 32'h1);
        chk(32'({tx_dma_req, rx_dma_req}), 32'h3);
        $display("test link done");
        wr(8'h00, 32'h0);
        rd(8'h0c);
        chk(32'(d[5:0] > 6'h2), 32'h1);
        rd(8'h10);
        rc(8'h10, 32'(PAT));
        $display("test rx done");
        end_sim();
    end
endmodule // stereo_audio_serial_port_bench
